//--- bfpt_pkg.sv
// Summary of operation
// - Status code: normal, start, retrip, failure, blocked
// - Blocking sampled once per processing tick
// - Pick-up unblocked raises START, timers run
// - Pick-up while blocked raises BLOCKED only
// - Late blocking clears START, timers release
// - Blocking raises notice and event with currents
// - Test switch blocks only in forcing mode
// - One pick-up starts both delay timers
// - Retrip enable, default on, hides retrip
// - RETRIP after retrip delay, 5 ms steps
// - Failure output after failure delay, 5 ms steps
// - Current-only mode ignores trip outputs
// - Current-and-output waits for trip output
// - Current-or-output runs while either active
// - Retrip off masks RETRIP; both timers still run
// - Comparators release below 97 percent threshold
// - Mode selector codes 0 to 10
// - Binary signals pick up without delay
package bfpt_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned TICK_US      = 5_000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned CUR_W        = 16;
  localparam int unsigned DLY_W        = 19;
  localparam int unsigned TICK_W       = 17;
  localparam int unsigned RELEASE_NUM  = 97;
  localparam int unsigned RELEASE_DEN  = 100;
  localparam logic [DLY_W-1:0] RETRIP_DLY_RST = 19'h0_0014;
  localparam logic [DLY_W-1:0] FAIL_DLY_RST   = 19'h0_0028;
  localparam logic RETRIP_EN_RST = 1'b1;

  typedef enum logic [3:0] {
    BFPT_MODE_CUR        = 4'h0,
    BFPT_MODE_DO         = 4'h1,
    BFPT_MODE_SIG        = 4'h2,
    BFPT_MODE_CUR_AND_DO = 4'h3,
    BFPT_MODE_CUR_OR_DO  = 4'h4,
    BFPT_MODE_CUR_AND_SG = 4'h5,
    BFPT_MODE_CUR_OR_SG  = 4'h6,
    BFPT_MODE_SG_AND_DO  = 4'h7,
    BFPT_MODE_SG_OR_DO   = 4'h8,
    BFPT_MODE_ANY        = 4'h9,
    BFPT_MODE_ALL        = 4'hA
  } bfpt_mode_t;

  typedef enum logic [2:0] {
    BFPT_ST_NORMAL  = 3'h0,
    BFPT_ST_START   = 3'h1,
    BFPT_ST_RETRIP  = 3'h2,
    BFPT_ST_FAIL    = 3'h3,
    BFPT_ST_BLOCKED = 3'h4
  } bfpt_status_t;

  typedef struct packed {
    logic [CUR_W-1:0] phase_a;
    logic [CUR_W-1:0] phase_b;
    logic [CUR_W-1:0] phase_c;
    logic [CUR_W-1:0] residual;
  } bfpt_meas_t;

  typedef struct packed {
    logic [CUR_W-1:0] max_phase;
    logic [CUR_W-1:0] residual;
    logic             phase_fault;
    logic             residual_fault;
  } bfpt_event_t;
endpackage

//--- bfpt_comparator.sv
`timescale 1ns/100ps
module bfpt_comparator (
  input  wire logic                               clock_i,
  input  wire logic                               reset_i,
  input  wire logic                               enable_i,
  input  wire logic                               tick_i,
  input  wire logic [bfpt_pkg::CUR_W-1:0]         value_i,
  input  wire logic [bfpt_pkg::CUR_W-1:0]         threshold_i,
  output logic                                    picked_o
);
  logic [bfpt_pkg::CUR_W+6:0] scaled_value;
  logic [bfpt_pkg::CUR_W+6:0] scaled_release;
  logic                       next_picked;

  always_comb begin
    scaled_value   = {7'h00, value_i} * 23'(bfpt_pkg::RELEASE_DEN);
    scaled_release = {7'h00, threshold_i} * 23'(bfpt_pkg::RELEASE_NUM);
    next_picked    = picked_o;
    if (tick_i) begin
      if (value_i > threshold_i) begin
        next_picked = 1'b1;
      end else if (scaled_value < scaled_release) begin
        next_picked = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      picked_o <= 1'b0;
    end else if (enable_i) begin
      picked_o <= next_picked;
    end
  end
endmodule

//--- bfpt_breaker_failure_protection_timing.sv
`timescale 1ns/100ps
module bfpt_breaker_failure_protection_timing #(
  parameter int unsigned TICK_CYCLES = bfpt_pkg::TICK_CYCLES
) (
  input  wire logic                           clock_i,
  input  wire logic                           reset_i,
  input  wire logic                           enable_i,
  input  wire bfpt_pkg::bfpt_meas_t           meas_i,
  input  wire logic [bfpt_pkg::CUR_W-1:0]     phase_pickup_threshold_i,
  input  wire logic [bfpt_pkg::CUR_W-1:0]     residual_pickup_threshold_i,
  input  wire logic                           residual_in_use_i,
  input  wire logic                           trip_output_i,
  input  wire logic                           trip_signal_i,
  input  wire logic                           block_i,
  input  wire logic                           test_block_switch_i,
  input  wire logic                           stage_forcing_i,
  input  wire logic [3:0]                     mode_i,
  input  wire logic                           retrip_enable_i,
  input  wire logic [bfpt_pkg::DLY_W-1:0]     redundant_trip_delay_i,
  input  wire logic [bfpt_pkg::DLY_W-1:0]     failure_delay_i,
  output logic                                start_o,
  output logic                                blocked_o,
  output logic                                retrip_o,
  output logic                                breaker_failure_output_o,
  output logic [2:0]                          function_status_code_o,
  output logic                                block_notice_o,
  output bfpt_pkg::bfpt_event_t               block_event_o
);
  logic [bfpt_pkg::TICK_W-1:0] tick_cnt;
  logic [bfpt_pkg::TICK_W-1:0] next_tick_cnt;
  logic                        tick;
  logic                        next_tick;
  logic [1:0]                  trip_out_sync;
  logic [1:0]                  trip_sig_sync;
  logic [1:0]                  block_sync;
  logic                        block_sampled;
  logic                        next_block_sampled;
  logic [2:0]                  phase_pick;
  logic                        res_pick;
  logic                        cur_pick;
  logic                        do_pick;
  logic                        sig_pick;
  logic                        pickup;
  logic                        run;
  logic [bfpt_pkg::DLY_W-1:0]  retrip_cnt;
  logic [bfpt_pkg::DLY_W-1:0]  fail_cnt;
  logic [bfpt_pkg::DLY_W-1:0]  next_retrip_cnt;
  logic [bfpt_pkg::DLY_W-1:0]  next_fail_cnt;
  logic                        next_start;
  logic                        next_blocked;
  logic                        next_retrip;
  logic                        next_fail;
  logic [2:0]                  next_status;
  logic                        next_notice;
  bfpt_pkg::bfpt_event_t       next_event;

  // Largest phase current is what the block event reports
  function automatic logic [bfpt_pkg::CUR_W-1:0] max2(
    input logic [bfpt_pkg::CUR_W-1:0] a,
    input logic [bfpt_pkg::CUR_W-1:0] b
  );
    max2 = (a > b) ? a : b;
  endfunction

  // Saturating count; a lowered delay trips at once, never wraps
  function automatic logic [bfpt_pkg::DLY_W-1:0] step(
    input logic [bfpt_pkg::DLY_W-1:0] cnt,
    input logic [bfpt_pkg::DLY_W-1:0] limit
  );
    step = (cnt < limit) ? cnt + 19'h0_0001 : cnt;
  endfunction

  // Blocked outranks failure, failure outranks retrip
  function automatic logic [2:0] status_of(
    input logic blk,
    input logic fail,
    input logic rtr,
    input logic st
  );
    if (blk)       status_of = 3'(bfpt_pkg::BFPT_ST_BLOCKED);
    else if (fail) status_of = 3'(bfpt_pkg::BFPT_ST_FAIL);
    else if (rtr)  status_of = 3'(bfpt_pkg::BFPT_ST_RETRIP);
    else if (st)   status_of = 3'(bfpt_pkg::BFPT_ST_START);
    else           status_of = 3'(bfpt_pkg::BFPT_ST_NORMAL);
  endfunction

  // Pins pass two flops; block sampled only on tick
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      trip_out_sync <= 2'h0;
      trip_sig_sync <= 2'h0;
      block_sync    <= 2'h0;
    end else if (enable_i) begin
      trip_out_sync <= {trip_out_sync[0], trip_output_i};
      trip_sig_sync <= {trip_sig_sync[0], trip_signal_i};
      block_sync    <= {block_sync[0], block_i};
    end
  end

  // Tick length is a parameter only so benches can shorten it
  always_comb begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt + 17'h0_0001;
    if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 17'h0_0000;
      next_tick     = 1'b1;
    end
    next_block_sampled = block_sampled;
    if (next_tick) begin
      next_block_sampled = block_sync[1] | (stage_forcing_i & test_block_switch_i);
    end
  end

  // Block sample is taken one edge before the tick acts
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_cnt      <= 17'h0_0000;
      tick          <= 1'b0;
      block_sampled <= 1'b0;
    end else if (enable_i) begin
      tick_cnt      <= next_tick_cnt;
      tick          <= next_tick;
      block_sampled <= next_block_sampled;
    end
  end

  // Comparators 0 to 2 watch the phases, 3 the residual input
  for (genvar i = 0; i < 4; i++) begin : g_cmp
    logic [bfpt_pkg::CUR_W-1:0] val;
    logic                       pick;
    assign val = meas_i[bfpt_pkg::CUR_W*(3-i) +: bfpt_pkg::CUR_W];
    bfpt_comparator u_cmp (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .enable_i    (enable_i),
      .tick_i      (tick),
      .value_i     (val),
      .threshold_i ((i == 3) ? residual_pickup_threshold_i : phase_pickup_threshold_i),
      .picked_o    (pick)
    );
  end
  assign phase_pick = {g_cmp[0].pick, g_cmp[1].pick, g_cmp[2].pick};
  assign res_pick   = g_cmp[3].pick & residual_in_use_i;

  // Pick-up per mode; binary inputs act with no delay
  always_comb begin
    cur_pick = (|phase_pick) | res_pick;
    do_pick  = trip_out_sync[1];
    sig_pick = trip_sig_sync[1];
    case (bfpt_pkg::bfpt_mode_t'(mode_i))
      bfpt_pkg::BFPT_MODE_CUR:        pickup = cur_pick;
      bfpt_pkg::BFPT_MODE_DO:         pickup = do_pick;
      bfpt_pkg::BFPT_MODE_SIG:        pickup = sig_pick;
      bfpt_pkg::BFPT_MODE_CUR_AND_DO: pickup = cur_pick & do_pick;
      bfpt_pkg::BFPT_MODE_CUR_OR_DO:  pickup = cur_pick | do_pick;
      bfpt_pkg::BFPT_MODE_CUR_AND_SG: pickup = cur_pick & sig_pick;
      bfpt_pkg::BFPT_MODE_CUR_OR_SG:  pickup = cur_pick | sig_pick;
      bfpt_pkg::BFPT_MODE_SG_AND_DO:  pickup = sig_pick & do_pick;
      bfpt_pkg::BFPT_MODE_SG_OR_DO:   pickup = sig_pick | do_pick;
      bfpt_pkg::BFPT_MODE_ANY:        pickup = cur_pick | do_pick | sig_pick;
      bfpt_pkg::BFPT_MODE_ALL:        pickup = cur_pick & do_pick & sig_pick;
      default:                        pickup = cur_pick;
    endcase
    run = pickup & ~block_sampled;
  end

  // Timers act on tick so all decisions use one block sample
  always_comb begin
    next_retrip_cnt = retrip_cnt;
    next_fail_cnt   = fail_cnt;
    next_start      = start_o;
    next_blocked    = blocked_o;
    next_retrip     = retrip_o;
    next_fail       = breaker_failure_output_o;
    next_notice     = 1'b0;
    next_event      = block_event_o;
    if (tick) begin
      next_start   = run;
      next_blocked = pickup & block_sampled;
      if (run) begin
        next_retrip_cnt = step(retrip_cnt, redundant_trip_delay_i);
        next_fail_cnt   = step(fail_cnt, failure_delay_i);
      end else begin
        next_retrip_cnt = 19'h0_0000;
        next_fail_cnt   = 19'h0_0000;
      end
      // A delay changed mid-run takes effect at the next tick
      next_retrip = run & retrip_enable_i & (next_retrip_cnt >= redundant_trip_delay_i);
      next_fail   = run & (next_fail_cnt >= failure_delay_i);
      // Event captured once, on the rising edge of blocked
      if (next_blocked & ~blocked_o) begin
        next_notice                = 1'b1;
        next_event.max_phase       = max2(max2(meas_i.phase_a, meas_i.phase_b), meas_i.phase_c);
        next_event.residual        = meas_i.residual;
        next_event.phase_fault     = |phase_pick;
        next_event.residual_fault  = res_pick;
      end
    end
    next_status = status_of(next_blocked, next_fail, next_retrip, next_start);
  end

  // Every output is a flop; status moves on the same edge
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      retrip_cnt               <= 19'h0_0000;
      fail_cnt                 <= 19'h0_0000;
      start_o                  <= 1'b0;
      blocked_o                <= 1'b0;
      retrip_o                 <= 1'b0;
      breaker_failure_output_o <= 1'b0;
      function_status_code_o   <= 3'h0;
      block_notice_o           <= 1'b0;
      block_event_o            <= '0;
    end else if (enable_i) begin
      retrip_cnt               <= next_retrip_cnt;
      fail_cnt                 <= next_fail_cnt;
      start_o                  <= next_start;
      blocked_o                <= next_blocked;
      retrip_o                 <= next_retrip;
      breaker_failure_output_o <= next_fail;
      function_status_code_o   <= next_status;
      block_notice_o           <= next_notice;
      block_event_o            <= next_event;
    end
  end
endmodule

//--- bfpt_props.sv
`timescale 1ns/100ps
module bfpt_props (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       retrip_enable_i,
  input  wire logic       start_o,
  input  wire logic       blocked_o,
  input  wire logic       retrip_o,
  input  wire logic       breaker_failure_output_o,
  input  wire logic [2:0] function_status_code_o,
  input  wire logic       block_notice_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  reset_clear_a:
    assert property (disable iff (1'b0) reset_i |=> !start_o && !blocked_o
      && function_status_code_o == 3'h0) else $error("Outputs not cleared by reset");
  code_block_a:
    assert property (blocked_o |-> function_status_code_o == 3'h4)
      else $error("Blocked status code wrong");
  code_fail_a:
    assert property (breaker_failure_output_o && !blocked_o |-> function_status_code_o == 3'h3)
      else $error("Failure status code wrong");
  code_retrip_a:
    assert property (retrip_o && !breaker_failure_output_o && !blocked_o
      |-> function_status_code_o == 3'h2) else $error("Retrip status code wrong");
  code_idle_a:
    assert property (!start_o && !blocked_o && !retrip_o && !breaker_failure_output_o
      |-> function_status_code_o == 3'h0) else $error("Idle status code wrong");
  block_quiet_a:
    assert property (blocked_o |-> !start_o && !retrip_o && !breaker_failure_output_o)
      else $error("Outputs active while blocked");
  retrip_off_a:
    assert property (!retrip_enable_i && !retrip_o |=> !retrip_o)
      else $error("Retrip raised while disabled");
  notice_pulse_a:
    assert property (block_notice_o |-> blocked_o ##1 !block_notice_o)
      else $error("Block notice not a single pulse");
  timer_start_a:
    assert property ($rose(retrip_o) || $rose(breaker_failure_output_o) |-> start_o)
      else $error("Timer output without start");
  tick_hold_a:
    assert property ($changed(start_o) |=> !$changed(start_o) [*8])
      else $error("Start changed between ticks");
  cover property ($rose(retrip_o));
  cover property ($rose(breaker_failure_output_o));
  cover property ($rose(blocked_o));
endmodule

bind bfpt_breaker_failure_protection_timing bfpt_props u_props (
  .clock_i(clock_i), .reset_i(reset_i), .retrip_enable_i(retrip_enable_i),
  .start_o(start_o), .blocked_o(blocked_o), .retrip_o(retrip_o),
  .breaker_failure_output_o(breaker_failure_output_o),
  .function_status_code_o(function_status_code_o), .block_notice_o(block_notice_o));

//--- bfpt_partner.sv
`timescale 1ns/100ps
module bfpt_partner #(
  parameter int unsigned CONTACT_CYCLES = 3
) (
  input  wire logic clock_i,
  input  wire logic trip_command_i,
  output logic      trip_output_o
);
  // Contact lag, far inside the margin kept between the two delays
  logic [CONTACT_CYCLES-1:0] pipe = '0;
  always_ff @(posedge clock_i) begin
    pipe <= {pipe[CONTACT_CYCLES-2:0], trip_command_i};
  end
  assign trip_output_o = pipe[CONTACT_CYCLES-1];
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] HI = 16'h0200;
  localparam logic [15:0] LO = 16'h0010;
  // Shortened tick keeps the run short; expectations count ticks
  localparam int unsigned TICK = 100;
  logic en = 1'b1, sig = 1'b0;
  logic clock = 1'b0, reset = 1'b1, trip_cmd = 1'b0, trip_out, blk = 1'b0;
  logic tsw = 1'b0, force_en = 1'b0, ren = 1'b1, start, blkd, retrip, bfo, notice;
  logic [3:0] mode = 4'h0;
  logic [2:0] code;
  // Retrip 3 ticks plus contact lag stays below failure 7 ticks
  logic [bfpt_pkg::DLY_W-1:0] rdly = 19'h0_0003, fdly = 19'h0_0007;
  bfpt_pkg::bfpt_meas_t meas = '{LO, 16'h0030, 16'h0020, 16'h0008};
  bfpt_pkg::bfpt_event_t ev;
  int mismatches = 0, compares = 0;
  int notices = 0;
  always #20 clock = ~clock;
  always @(posedge clock) if (notice === 1'b1) notices++;
  bfpt_partner pm (.clock_i(clock), .trip_command_i(trip_cmd), .trip_output_o(trip_out));
  bfpt_breaker_failure_protection_timing #(.TICK_CYCLES(TICK)) dut (.clock_i(clock),
    .reset_i(reset), .enable_i(en), .meas_i(meas), .phase_pickup_threshold_i(16'h0100),
    .residual_pickup_threshold_i(16'h0100), .residual_in_use_i(1'b1),
    .trip_output_i(trip_out), .trip_signal_i(sig), .block_i(blk),
    .test_block_switch_i(tsw), .stage_forcing_i(force_en), .mode_i(mode),
    .retrip_enable_i(ren), .redundant_trip_delay_i(rdly), .failure_delay_i(fdly),
    .start_o(start), .blocked_o(blkd), .retrip_o(retrip), .breaker_failure_output_o(bfo),
    .function_status_code_o(code), .block_notice_o(notice), .block_event_o(ev));
  task automatic conclude;
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [3:0] srfb, input logic [2:0] c);
    chk_b(start, srfb[3]);
    chk_b(retrip, srfb[2]);
    chk_b(bfo, srfb[1]);
    chk_b(blkd, srfb[0]);
    chk_v(34'(code), 34'(c));
  endtask
  // Checks sit mid-tick, where every output has settled
  task automatic adv(input int n);
    repeat (n * TICK) @(posedge clock);
  endtask
  task automatic set_cur(input logic [15:0] a);
    @(posedge clock);
    meas.phase_a <= a;
  endtask
  task automatic idle;
    set_cur(LO);
    {blk, trip_cmd, tsw, force_en, sig} <= 5'h00;
    mode <= 4'h0;
    adv(3);
  endtask
  task automatic t_cur_only;
    set_cur(HI);
    trip_cmd <= 1'b1;
    adv(1); st(4'h0, 3'h0);
    adv(1); st(4'h8, 3'h1);
    trip_cmd <= 1'b0;
    adv(2); st(4'hC, 3'h2);
    set_cur(16'h00FB);
    adv(4); st(4'hE, 3'h3);
    set_cur(16'h00F0);
    adv(2); st(4'h0, 3'h0);
    idle;
  endtask
  task automatic t_freeze;
    set_cur(HI);
    adv(2); st(4'h8, 3'h1);
    en <= 1'b0;
    adv(5); st(4'h8, 3'h1);
    en <= 1'b1;
    adv(2); st(4'hC, 3'h2);
    idle;
  endtask
  task automatic t_and_do;
    mode <= 4'h3;
    set_cur(HI);
    adv(4); chk_b(retrip | bfo, 1'b0);
    trip_cmd <= 1'b1;
    adv(5); chk_b(retrip, 1'b1);
    chk_b(bfo, 1'b0);
    trip_cmd <= 1'b0;
    adv(2); chk_b(retrip, 1'b0);
    idle;
  endtask
  task automatic t_or_do;
    mode <= 4'h4;
    trip_cmd <= 1'b1;
    adv(5); chk_b(retrip, 1'b1);
    set_cur(HI);
    adv(2);
    trip_cmd <= 1'b0;
    adv(2); chk_b(start & retrip, 1'b1);
    set_cur(LO);
    adv(2); chk_b(start, 1'b0);
    idle;
  endtask
  task automatic t_signal;
    mode <= 4'h2;
    sig <= 1'b1;
    adv(1); st(4'h8, 3'h1);
    mode <= 4'h7;
    adv(1); chk_b(start, 1'b0);
    mode <= 4'hA;
    trip_cmd <= 1'b1;
    set_cur(HI);
    adv(1); chk_b(start, 1'b0);
    adv(1); chk_b(start, 1'b1);
    idle;
  endtask
  task automatic t_retrip_off;
    ren <= 1'b0;
    set_cur(HI);
    adv(9); st(4'hA, 3'h3);
    idle;
    ren <= 1'b1;
  endtask
  task automatic t_block;
    blk <= 1'b1;
    adv(1);
    set_cur(HI);
    adv(3); st(4'h1, 3'h4);
    chk_v(ev, {HI, 16'h0008, 1'b1, 1'b0});
    chk_v(34'(notices), 34'h0_0000_0001);
    idle;
  endtask
  task automatic t_late_block;
    set_cur(HI);
    adv(2); chk_b(start, 1'b1);
    blk <= 1'b1;
    adv(3); chk_v(34'({start, retrip, bfo}), 34'h0_0000_0000);
    idle;
  endtask
  task automatic t_test_switch;
    tsw <= 1'b1;
    set_cur(HI);
    adv(2); chk_v(34'({start, blkd}), 34'h0_0000_0002);
    force_en <= 1'b1;
    adv(2); chk_v(34'({start, retrip}), 34'h0_0000_0000);
    idle;
  endtask
  initial begin
    repeat (120 * TICK) @(posedge clock);
    mismatches++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (TICK / 2) @(posedge clock);
    st(4'h0, 3'h0);
    t_cur_only;
    t_freeze;
    t_and_do;
    t_or_do;
    t_signal;
    t_retrip_off;
    t_block;
    t_late_block;
    t_test_switch;
    conclude;
  end
endmodule
